// file: verilog/rfts_defs.svh
// constants of the transparent and stream mode codec
`ifndef RFTS_DEFS_SVH
`define RFTS_DEFS_SVH

// sub-carrier stream: fc/64 at scf 00, halved per step
`define RFTS_SUB_SC_BASE 10'h040
// bpsk stream: fc/16 at scf 00, halved per step
`define RFTS_BPSK_SC_BASE 10'h010
// bpsk frequency select ceiling (fc/4)
`define RFTS_BPSK_SCF_MAX 2'h2
// least period select in sub-carrier mode, two sub-carrier cycles
`define RFTS_SUB_SCP_MIN 3'h1
// largest period select, eight sub-carrier cycles
`define RFTS_SCP_MAX 3'h3
// stream transmit bit period at stx 000b, in fc cycles
`define RFTS_TX_BASE 8'h80
// empty reporting periods tolerated before end of receive
`define RFTS_QUIET_MAX 4'h8
// index of the last bit in a byte
`define RFTS_BYTE_LAST 3'h7
// operation control value that means all blocks off
`define RFTS_OPC_IDLE 8'h00
// saturation point of the per-period edge counter
`define RFTS_EDGE_MAX 6'h3F
// phase sample point, as a right shift of the sub-carrier length
`define RFTS_PH_SHIFT 2
// fifo depth in the receive path
`define RFTS_FIFO_DEPTH 4

`endif

// file: verilog/rfts_pkg.sv
// types shared by the transparent and stream mode codec
package rfts_pkg;

  // receive engine states
  typedef enum logic [1:0] {
    rx_off,
    rx_hunt,
    rx_recv
  } rfts_rx_t;

  // software configuration bits
  typedef struct packed {
    logic stream_en;
    logic bpsk;
    logic [1:0] scf;
    logic [2:0] scp;
    logic [2:0] stx;
    logic am_en;
    logic pm_en;
    logic ext_field_detect_enable;
    logic [7:0] op_ctrl;
    logic rx_on_cfg;
  } rfts_cfg_t;

  // spi pins as seen by the codec
  typedef struct packed {
    logic sel_n;
    logic mosi;
    logic sclk;
  } rfts_spi_t;

  // digitised outputs of the analog front end
  typedef struct packed {
    logic am;
    logic pm;
    logic field;
  } rfts_demod_t;

  // whole state of the codec core
  typedef struct packed {
    rfts_rx_t rx;
    logic sel_q;
    logic armed;
    logic xp;
    logic lpt;
    logic fd_q;
    logic eon;
    logic tx_mod;
    logic rx_on;
    logic miso;
    logic miso_drive;
    logic irq;
    logic [9:0] prd_cnt;
    logic [5:0] edges;
    logic last_in;
    logic ph_smp;
    logic init_ph;
    logic [3:0] quiet;
    logic [7:0] shreg;
    logic [2:0] bcnt;
    logic pend;
    logic [7:0] pend_byte;
    logic ovf;
    logic rx_start;
    logic rx_end;
    logic tx_have;
    logic [7:0] tx_byte;
    logic [2:0] tx_bcnt;
    logic [7:0] tx_cnt;
  } rfts_state_t;

endpackage : rfts_pkg

// file: verilog/rfts_fifo.sv
// small flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module rfts_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import rfts_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  // fifo state: storage, pointers, fill level
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rfts_fifo_st_t;

  rfts_fifo_st_t s_q; // registered state
  rfts_fifo_st_t s_d; // next state

  logic push; // write accepted
  logic pop; // read accepted

  assign in_ready = (s_q.cnt != FULL);
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer wrap at depth
  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  // next state
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = wrap_inc(s_q.wp);
    end
    if (pop) begin
      s_d.rp = wrap_inc(s_q.rp);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : rfts_fifo

// file: verilog/rfts_core.sv
// transparent mode pin mux and stream mode bit codec
`timescale 1ns/1ps
`include "rfts_defs.svh"

// Notes on behaviour
// - armed command plus select rise enters transparent
// - transparent: modulator follows mosi
// - transparent: receiver-active follows sclk
// - transparent: am channel drives miso
// - transparent: pm channel drives interrupt pin
// - single channel goes to miso, irq low
// - transparent ignores stream, framing, fifo settings
// - any spi command leaves transparent mode
// - field detect enable routes detector to irq
// - idle op control plus detect: low-power target
// - first bit in time sits in lsb
// - sub-carrier: fc/64..fc/8, two..eight cycles
// - first sub-carrier period starts receive, writes bit
// - sub-carrier: one bit per period, 1=present
// - sub-carrier: end after nine empty periods
// - sub-carrier: scf 01 fc/32, scp 10 four
// - bpsk: fc/16..fc/4, one..eight cycles
// - bpsk: 0 initial phase, 1 inverted
// - bpsk: first empty period ends receive
// - bpsk: scf 01 fc/8, scp 01 two
// - stream transmit: fifo bit drives modulator
// - stx 000 gives 128 fc bit period
module rfts_core #(
  parameter int FIFO_DEPTH = `RFTS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire rfts_pkg::rfts_spi_t spi,
  input wire logic cmd_transparent,
  input wire logic cmd_any,
  input wire rfts_pkg::rfts_cfg_t cfg,
  input wire rfts_pkg::rfts_demod_t demod,
  input wire logic fc_tick,
  input wire logic rx_enable,
  input wire logic tx_enable,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic miso_norm,
  input wire logic miso_norm_oe_n,
  input wire logic irq_norm,
  output logic miso_o,
  output logic miso_oe_n,
  output logic irq_o,
  output logic tx_mod,
  output logic rx_on,
  output logic transparent,
  output logic low_power_target,
  output logic irq_eon,
  output logic rx_start,
  output logic rx_end,
  output logic rx_ovf,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  import rfts_pkg::*;

  rfts_state_t s_q; // registered state
  rfts_state_t s_d; // next state

  logic push_ready; // fifo can take the pending byte
  logic stream_act; // stream engine allowed to run
  logic tx_run; // stream transmit running
  logic [9:0] sc_len; // fc cycles per sub-carrier cycle
  logic [9:0] prd_len; // fc cycles per reporting period
  logic [5:0] ncyc; // sub-carrier cycles per period
  logic [7:0] tx_len; // fc cycles per transmit bit

  // fc cycles in one sub-carrier cycle
  function automatic logic [9:0] sub_len(input logic bpsk, input logic [1:0] scf);
    logic [1:0] f;
    f = scf;
    if (bpsk) begin
      if (f > `RFTS_BPSK_SCF_MAX) f = `RFTS_BPSK_SCF_MAX;
      sub_len = `RFTS_BPSK_SC_BASE >> f;
    end else begin
      sub_len = `RFTS_SUB_SC_BASE >> f;
    end
  endfunction : sub_len

  // sub-carrier cycles in one reporting period
  function automatic logic [5:0] cyc_cnt(input logic bpsk, input logic [2:0] scp);
    logic [2:0] p;
    p = scp;
    if (!bpsk && p < `RFTS_SUB_SCP_MIN) p = `RFTS_SUB_SCP_MIN;
    if (p > `RFTS_SCP_MAX) p = `RFTS_SCP_MAX;
    cyc_cnt = 6'h01 << p;
  endfunction : cyc_cnt

  // period geometry from the stream settings
  always_comb begin
    sc_len = sub_len(cfg.bpsk, cfg.scf);
    ncyc = cyc_cnt(cfg.bpsk, cfg.scp);
    prd_len = 10'(sc_len * ncyc);
    tx_len = `RFTS_TX_BASE >> cfg.stx;
  end

  // stream logic is held off in transparent mode
  assign stream_act = cfg.stream_en & ~s_q.xp;
  assign tx_run = stream_act & tx_enable;
  assign tx_ready = tx_run & ~s_q.tx_have;

  // next state
  always_comb begin
    logic in_v;
    logic edge_v;
    logic [5:0] e_v;
    logic det_v;
    logic wr_v;
    logic bit_v;
    logic end_v;
    logic single_v;
    in_v = 1'b0;
    edge_v = 1'b0;
    e_v = '0;
    det_v = 1'b0;
    wr_v = 1'b0;
    bit_v = 1'b0;
    end_v = 1'b0;
    single_v = cfg.am_en ^ cfg.pm_en;
    s_d = s_q;
    s_d.rx_start = 1'b0;
    s_d.rx_end = 1'b0;
    s_d.eon = 1'b0;
    s_d.sel_q = spi.sel_n;

    // transparent mode entry and exit
    if (cmd_transparent) begin
      s_d.armed = 1'b1;
      s_d.xp = 1'b0;
    end else if (cmd_any) begin
      s_d.armed = 1'b0;
      s_d.xp = 1'b0;
    end else if (s_q.armed && spi.sel_n && !s_q.sel_q) begin
      s_d.armed = 1'b0;
      s_d.xp = 1'b1;
    end else if (s_q.xp && !spi.sel_n) begin
      s_d.xp = 1'b0;
    end

    // pin multiplexer
    if (s_q.xp) begin
      s_d.tx_mod = spi.mosi;
      s_d.rx_on = spi.sclk;
      s_d.miso = (cfg.pm_en && !cfg.am_en) ? demod.pm : demod.am;
      s_d.miso_drive = 1'b1;
      if (cfg.ext_field_detect_enable) begin
        s_d.irq = demod.field;
      end else if (single_v) begin
        s_d.irq = 1'b0;
      end else begin
        s_d.irq = demod.pm;
      end
    end else begin
      s_d.tx_mod = s_q.tx_have & s_q.tx_byte[s_q.tx_bcnt];
      s_d.rx_on = cfg.rx_on_cfg;
      s_d.miso = miso_norm;
      s_d.miso_drive = ~miso_norm_oe_n;
      s_d.irq = irq_norm;
    end

    // low-power target mode and field-on event
    s_d.lpt = cfg.ext_field_detect_enable && (cfg.op_ctrl == `RFTS_OPC_IDLE);
    s_d.fd_q = demod.field;
    if (s_q.lpt && demod.field && !s_q.fd_q) begin
      s_d.eon = 1'b1;
    end

    // pending byte leaves for the fifo
    if (s_q.pend && push_ready) begin
      s_d.pend = 1'b0;
    end

    // receive engine
    if (!stream_act || !rx_enable) begin
      s_d.rx = rx_off;
      s_d.prd_cnt = '0;
      s_d.edges = '0;
      s_d.bcnt = '0;
      s_d.shreg = '0;
    end else if (s_q.rx == rx_off) begin
      s_d.rx = rx_hunt;
      s_d.prd_cnt = '0;
      s_d.edges = '0;
    end else if (fc_tick) begin
      // edge counting on the selected channel
      in_v = (cfg.pm_en && !cfg.am_en) ? demod.pm : demod.am;
      edge_v = in_v ^ s_q.last_in;
      s_d.last_in = in_v;
      e_v = s_q.edges;
      if (edge_v && e_v != `RFTS_EDGE_MAX) e_v = e_v + 1'b1;
      s_d.edges = e_v;
      if (s_q.prd_cnt == (sc_len >> `RFTS_PH_SHIFT)) begin
        s_d.ph_smp = in_v;
      end
      if (s_q.prd_cnt == prd_len - 1'b1) begin
        // end of one reporting period
        s_d.prd_cnt = '0;
        s_d.edges = '0;
        det_v = (e_v >= ncyc);
        unique case (s_q.rx)
          rx_hunt: begin
            if (det_v) begin
              s_d.rx_start = 1'b1;
              s_d.rx = rx_recv;
              s_d.quiet = '0;
              s_d.init_ph = s_q.ph_smp;
              wr_v = 1'b1;
              bit_v = ~cfg.bpsk;
            end
          end
          rx_recv: begin
            if (cfg.bpsk) begin
              if (!det_v) begin
                end_v = 1'b1;
              end else begin
                wr_v = 1'b1;
                bit_v = s_q.ph_smp ^ s_q.init_ph;
              end
            end else if (det_v) begin
              s_d.quiet = '0;
              wr_v = 1'b1;
              bit_v = 1'b1;
            end else if (s_q.quiet == `RFTS_QUIET_MAX) begin
              end_v = 1'b1;
            end else begin
              s_d.quiet = s_q.quiet + 1'b1;
              wr_v = 1'b1;
              bit_v = 1'b0;
            end
          end
          default: begin
            s_d.rx = rx_off;
          end
        endcase
      end else begin
        s_d.prd_cnt = s_q.prd_cnt + 1'b1;
      end
    end

    // byte assembly, first bit in lsb
    if (wr_v) begin
      s_d.shreg[s_q.bcnt] = bit_v;
      if (s_q.bcnt == `RFTS_BYTE_LAST) begin
        if (s_d.pend) begin
          s_d.ovf = 1'b1;
        end else begin
          s_d.pend = 1'b1;
          s_d.pend_byte = s_d.shreg;
        end
        s_d.shreg = '0;
        s_d.bcnt = '0;
      end else begin
        s_d.bcnt = s_q.bcnt + 1'b1;
      end
    end
    if (end_v) begin
      s_d.rx_end = 1'b1;
      s_d.rx = rx_hunt;
      s_d.quiet = '0;
      if (s_q.bcnt != '0) begin
        if (s_d.pend) begin
          s_d.ovf = 1'b1;
        end else begin
          s_d.pend = 1'b1;
          s_d.pend_byte = s_q.shreg;
        end
        s_d.shreg = '0;
        s_d.bcnt = '0;
      end
    end

    // stream transmit, one fifo bit per bit period
    if (!tx_run) begin
      s_d.tx_have = 1'b0;
      s_d.tx_cnt = '0;
      s_d.tx_bcnt = '0;
    end else if (!s_q.tx_have) begin
      if (tx_valid) begin
        s_d.tx_have = 1'b1;
        s_d.tx_byte = tx_data;
        s_d.tx_bcnt = '0;
        s_d.tx_cnt = '0;
      end
    end else if (fc_tick) begin
      if (s_q.tx_cnt == tx_len - 1'b1) begin
        s_d.tx_cnt = '0;
        if (s_q.tx_bcnt == `RFTS_BYTE_LAST) begin
          s_d.tx_have = 1'b0;
        end else begin
          s_d.tx_bcnt = s_q.tx_bcnt + 1'b1;
        end
      end else begin
        s_d.tx_cnt = s_q.tx_cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // receive byte buffer
  rfts_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(s_q.pend),
    .in_ready(push_ready),
    .in_data(s_q.pend_byte),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  // outputs straight from the state register
  assign miso_o = s_q.miso;
  assign miso_oe_n = ~s_q.miso_drive;
  assign irq_o = s_q.irq;
  assign tx_mod = s_q.tx_mod;
  assign rx_on = s_q.rx_on;
  assign transparent = s_q.xp;
  assign low_power_target = s_q.lpt;
  assign irq_eon = s_q.eon;
  assign rx_start = s_q.rx_start;
  assign rx_end = s_q.rx_end;
  assign rx_ovf = s_q.ovf;

  // checks
  property p_enter;
    @(posedge clk) disable iff (!rst_n)
    (s_q.armed && !cmd_any && !cmd_transparent && $rose(spi.sel_n)) |=> transparent;
  endproperty
  a_enter: assert property (p_enter) else $error("no entry on select rise");

  property p_mosi;
    @(posedge clk) disable iff (!rst_n)
    transparent |=> (tx_mod == $past(spi.mosi));
  endproperty
  a_mosi: assert property (p_mosi) else $error("modulator not following mosi");

  property p_sclk;
    @(posedge clk) disable iff (!rst_n)
    transparent |=> (rx_on == $past(spi.sclk));
  endproperty
  a_sclk: assert property (p_sclk) else $error("rx_on not following sclk");

  property p_miso;
    @(posedge clk) disable iff (!rst_n)
    (transparent && cfg.am_en) |=> (miso_o == $past(demod.am)) && !miso_oe_n;
  endproperty
  a_miso: assert property (p_miso) else $error("miso not carrying am");

  property p_pm_irq;
    @(posedge clk) disable iff (!rst_n)
    (transparent && cfg.am_en && cfg.pm_en && !cfg.ext_field_detect_enable)
      |=> (irq_o == $past(demod.pm));
  endproperty
  a_pm_irq: assert property (p_pm_irq) else $error("irq not carrying pm");

  property p_single;
    @(posedge clk) disable iff (!rst_n)
    (transparent && (cfg.am_en ^ cfg.pm_en) && !cfg.ext_field_detect_enable) |=> !irq_o;
  endproperty
  a_single: assert property (p_single) else $error("irq not low in single channel");

  property p_quiet_stream;
    @(posedge clk) disable iff (!rst_n)
    transparent |-> !tx_ready ##1 (s_q.rx == rx_off);
  endproperty
  a_quiet_stream: assert property (p_quiet_stream) else $error("stream active");

  property p_exit;
    @(posedge clk) disable iff (!rst_n)
    (cmd_any && !cmd_transparent) |=> !transparent ##1 !transparent;
  endproperty
  a_exit: assert property (p_exit) else $error("command did not leave mode");

  property p_fd;
    @(posedge clk) disable iff (!rst_n)
    (transparent && cfg.ext_field_detect_enable) |=> (irq_o == $past(demod.field));
  endproperty
  a_fd: assert property (p_fd) else $error("detector not on irq");

  property p_eon;
    @(posedge clk) disable iff (!rst_n)
    (low_power_target && $rose(demod.field)) |=> irq_eon;
  endproperty
  a_eon: assert property (p_eon) else $error("field-on event missed");

  property p_end_flush;
    @(posedge clk) disable iff (!rst_n)
    (s_d.rx_end && s_q.bcnt != '0 && !s_q.pend) |=> s_q.pend ##1 rx_end == 1'b0;
  endproperty
  a_end_flush: assert property (p_end_flush) else $error("partial byte not flushed");

endmodule : rfts_core

// file: tb/rfts_mcu.sv
// controller model: select pin and decoded command pulses
`timescale 1ns/1ps
module rfts_mcu (
  input wire logic clk,
  output logic sel_n,
  output logic cmd_transparent,
  output logic cmd_any
);
  // idle: select low, no command
  initial begin
    sel_n = 1'b0;
    cmd_transparent = 1'b0;
    cmd_any = 1'b0;
  end
  // one command frame, select low, one-cycle decode pulse
  task automatic command(input bit xp);
    @(posedge clk);
    #1;
    sel_n = 1'b0;
    cmd_transparent = xp;
    cmd_any = !xp;
    @(posedge clk);
    #1;
    cmd_transparent = 1'b0;
    cmd_any = 1'b0;
  endtask : command
  // release select, held high afterwards
  task automatic rise();
    @(posedge clk);
    #1;
    sel_n = 1'b1;
  endtask : rise
  // front end is set up by the caller before this
  task automatic enter();
    command(1'b1);
    rise();
  endtask : enter
  // any other command, e.g. field gating around a transmission
  task automatic leave();
    command(1'b0);
  endtask : leave
endmodule : rfts_mcu

// file: tb/testbench.sv
// self-checking bench of the transparent and stream mode codec
`timescale 1ns/1ps
module testbench;
  import rfts_pkg::*;
  logic clk, rst_n, fc_tick, rx_enable, tx_enable, tx_valid, tx_ready, rx_ready;
  logic mosi, sclk, sel_n, cmd_t, cmd_a, miso_norm, miso_norm_oe_n, irq_norm;
  logic miso_o, miso_oe_n, irq_o, tx_mod, rx_on, transparent, low_power_target;
  logic irq_eon, rx_start, rx_end, rx_ovf, rx_valid;
  logic [7:0] tx_data, rx_data;
  rfts_cfg_t cfg;
  rfts_demod_t demod;
  int errors, check_count, cyc, n_start, n_end, rdy_mode;
  logic [7:0] got_q[$], exp_q[$];
  rfts_mcu u_mcu (.clk(clk), .sel_n(sel_n), .cmd_transparent(cmd_t), .cmd_any(cmd_a));
  rfts_core u_dut (.clk(clk), .rst_n(rst_n), .spi({sel_n, mosi, sclk}),
    .cmd_transparent(cmd_t), .cmd_any(cmd_a), .cfg(cfg), .demod(demod),
    .fc_tick(fc_tick), .rx_enable(rx_enable), .tx_enable(tx_enable), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .miso_norm(miso_norm),
    .miso_norm_oe_n(miso_norm_oe_n), .irq_norm(irq_norm), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .irq_o(irq_o), .tx_mod(tx_mod), .rx_on(rx_on),
    .transparent(transparent), .low_power_target(low_power_target), .irq_eon(irq_eon),
    .rx_start(rx_start), .rx_end(rx_end), .rx_ovf(rx_ovf), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // verdict and end of run
  task automatic close_out();
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // one comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // hang guard, receive collection and event counts
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      close_out();
    end
    if (rst_n === 1'b1 && rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back(rx_data);
    if (rx_start === 1'b1) n_start++;
    if (rx_end === 1'b1) n_end++;
  end
  // fifo drain side: stalled or random
  always @(posedge clk) begin
    #1;
    rx_ready = (rdy_mode != 0) ? 1'($urandom % 2) : 1'b0;
  end
  // random pins in transparent mode, outputs one cycle later
  task automatic xp_run(input int n);
    logic pm0, am0, fd0, mo0, sc0;
    for (int i = 0; i < n; i++) begin
      {pm0, am0, fd0, mo0, sc0} = {demod.pm, demod.am, demod.field, mosi, sclk};
      @(posedge clk);
      #1;
      chk(tx_mod, mo0, "mod");
      chk(rx_on, sc0, "rx_on");
      chk(miso_o, (cfg.pm_en && !cfg.am_en) ? pm0 : am0, "miso");
      chk(irq_o, cfg.ext_field_detect_enable ? fd0 : (cfg.am_en ^ cfg.pm_en) ? 1'b0 : pm0,
          "irq");
      chk(miso_oe_n, 1'b0, "oe");
      {mosi, sclk, demod, miso_norm, irq_norm} = 7'($urandom);
    end
  endtask : xp_run
  // one received frame: model bytes, then drive the sub-carrier per fc tick
  task automatic rx_frame(input int sl, input int nc, input bit bp, input int nb);
    bit b[$];
    bit ph[$];
    logic [7:0] by;
    int per, s0, e0;
    per = sl * nc;
    s0 = n_start;
    e0 = n_end;
    for (int i = 0; i < nb; i++) begin
      // a forced one every eight periods keeps empty runs short of the end count
      ph.push_back(i == 0 || i == nb - 1 || i % 8 == 4 || ($urandom % 2) == 1);
      b.push_back(bp ? ph[i] ^ ph[0] : ph[i]);
    end
    if (!bp) repeat (8) b.push_back(1'b0);
    by = 8'h00;
    foreach (b[i]) begin
      by[i % 8] = b[i];
      if (i % 8 == 7 || i == b.size() - 1) begin
        exp_q.push_back(by);
        by = 8'h00;
      end
    end
    rx_enable = 1'b1;
    for (int p = -1; p < nb + 10; p++) begin
      for (int t = 0; t < per; t++) begin
        @(posedge clk);
        #1;
        if (p < 0 || p >= nb || (!bp && !ph[p])) demod.am = 1'b0;
        else if (bp) demod.am = 1'((((t + 1) % sl) < sl / 2) ^ ph[p]);
        else demod.am = 1'((t % sl) >= sl / 4 && (t % sl) < 3 * sl / 4);
      end
    end
    rx_enable = 1'b0;
    chk(8'(n_start - s0), 8'h01, "start");
    chk(8'(n_end - e0), 8'h01, "end");
  endtask : rx_frame
  // compare collected bytes with the model
  task automatic cmp_q();
    repeat (200) @(posedge clk);
    #1;
    chk(8'(got_q.size()), 8'(exp_q.size()), "count");
    foreach (exp_q[i]) if (i < got_q.size()) chk(got_q[i], exp_q[i], "byte");
    got_q.delete();
    exp_q.delete();
  endtask : cmp_q
  // main sequence
  initial begin
    logic got;
    logic [7:0] txb;
    int sl_t[5] = '{32, 8, 64, 8, 4};
    int nc_t[5] = '{4, 2, 8, 2, 1};
    logic [6:0] sc_t[5] = '{7'h12, 7'h30, 7'h03, 7'h11, 7'h20};
    rst_n = 1'b0;
    fc_tick = 1'b1;
    {rx_enable, tx_enable, tx_valid, mosi, sclk, miso_norm, irq_norm} = '0;
    miso_norm_oe_n = 1'b1;
    tx_data = 8'h00;
    demod = '0;
    cfg = '0;
    cfg.op_ctrl = 8'hC3;
    cfg.rx_on_cfg = 1'b1;
    rdy_mode = 1;
    void'($urandom(5561));
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({transparent, miso_oe_n, tx_ready}, 8'h02, "reset");
    // channel and detector routing combinations
    for (int k = 0; k < 4; k++) begin
      {cfg.am_en, cfg.pm_en, cfg.ext_field_detect_enable} = (k == 0) ? 3'h6 : (k == 1) ? 3'h4 :
          (k == 2) ? 3'h2 : 3'h7;
      cfg.stream_en = 1'b1;
      rx_enable = 1'b1;
      n_start = 0;
      u_mcu.enter();
      repeat (3) @(posedge clk);
      #1;
      chk(transparent, 1'b1, "enter");
      xp_run(24);
      chk(8'(n_start), 8'h00, "held");
      rx_enable = 1'b0;
      u_mcu.leave();
      repeat (2) @(posedge clk);
      #1;
      chk(transparent, 1'b0, "leave");
    end
    u_mcu.rise();
    repeat (3) @(posedge clk);
    #1;
    chk(transparent, 1'b0, "unarmed");
    u_mcu.leave();
    // low-power target and field wake
    demod = '0;
    cfg.op_ctrl = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    chk(low_power_target, 1'b1, "lpt");
    demod.field = 1'b1;
    got = 1'b0;
    repeat (3) begin
      @(posedge clk);
      #1;
      got = got | irq_eon;
    end
    chk(got, 1'b1, "eon");
    cfg.op_ctrl = 8'h03;
    repeat (2) @(posedge clk);
    #1;
    chk(low_power_target, 1'b0, "lpt off");
    // stream receive, configured after stream selection
    {cfg.am_en, cfg.pm_en, cfg.ext_field_detect_enable} = 3'h4;
    for (int k = 0; k < 5; k++) begin
      {cfg.bpsk, cfg.scf, cfg.scp} = {(k > 2), sc_t[k][5:4], sc_t[k][2:0]};
      rx_frame(sl_t[k], nc_t[k], k > 2, 12 + k);
      cmp_q();
    end
    // stalled drain: fifo and pending fill, rest dropped
    {cfg.bpsk, cfg.scf, cfg.scp} = 6'h18;
    rdy_mode = 0;
    rx_frame(8, 2, 1'b0, 48);
    chk(rx_ovf, 1'b1, "ovf");
    while (exp_q.size() > 5) void'(exp_q.pop_back());
    rdy_mode = 1;
    cmp_q();
    // stream transmit, refused until enabled
    cfg.stx = 3'h0;
    repeat (2) @(posedge clk);
    #1;
    chk(tx_ready, 1'b0, "tx refused");
    tx_enable = 1'b1;
    for (int i = 0; i < 20 && tx_ready !== 1'b1; i++) @(posedge clk);
    #1;
    txb = 8'($urandom);
    tx_data = txb;
    tx_valid = 1'b1;
    @(posedge clk);
    #1;
    tx_valid = 1'b0;
    repeat (63) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      chk(tx_mod, txb[i], "tx bit");
      repeat (127) @(posedge clk);
    end
    close_out();
  end
endmodule : testbench
